//--- hw/pcer_pkg.sv
// shared constants and types of the power control register block
package pcer_pkg;

    localparam logic [7:0] ADDR_STATUS = 8'h05;
    localparam logic [7:0] ADDR_CTRL = 8'h06;
    localparam logic [7:0] ADDR_FLAGS = 8'h07;
    localparam logic [7:0] ADDR_KEY = 8'h10;
    localparam logic [7:0] ADDR_EN1 = 8'h11;

    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_KEY_READ = 8'h00;
    localparam logic [7:0] RST_EN1 = 8'h00;

    localparam int CTRL_CC_BIT = 0;
    localparam int CTRL_PF_BIT = 1;
    localparam int STATUS_SEAL_BIT = 7;
    localparam logic [1:0] STATE_SUSPEND = 2'h3;

    // arbitrary unlock value and bus address, neutral defaults
    localparam logic [7:0] UNLOCK_KEY = 8'h5a;
    localparam logic [6:0] DEV_ADDR = 7'h2a;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_ADDR  = 8'h02,
        ST_SUB   = 8'h04,
        ST_DATA  = 8'h08,
        ST_ACK   = 8'h10,
        ST_READ  = 8'h20,
        ST_RACK  = 8'h40,
        ST_RLOAD = 8'h80
    } pcer_i2c_st_t;

    typedef struct packed {
        logic meta;
        logic sync;
    } pcer_sync_s_t;

    typedef struct packed {
        logic scl1;
        logic scl2;
        logic scl3;
        logic sda1;
        logic sda2;
        logic sda3;
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic sda;
    } pcer_phy_s_t;

    typedef struct packed {
        pcer_i2c_st_t st;
        pcer_i2c_st_t after;
        logic [7:0] shreg;
        logic [3:0] cnt;
        logic [7:0] addr;
        logic ackPh;
        logic sdaOe;
        logic sdaOut;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic pfEn;
        logic ccTrig;
        logic pfShut;
        logic [7:0] flags;
        logic [5:0] enable;
        logic unlocked;
        logic [1:0] prevState;
    } pcer_top_s_t;

endpackage

//--- hw/pcer_i2c_ev_if.sv
// bus events passed from the pin front end to the byte engine
`timescale 1ns/1ps
interface pcer_i2c_ev_if;
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
    logic sda;
    modport phy (output sclRise, sclFall, start, stop, sda);
    modport eng (input sclRise, sclFall, start, stop, sda);
endinterface

//--- hw/pcer_sync.sv
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module pcer_sync
    import pcer_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic din,
    output logic dout
);
    pcer_sync_s_t s_q;
    pcer_sync_s_t s_d;

    always_comb begin
        s_d.meta = din;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '{meta: 1'b1, sync: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.sync;
endmodule

//--- hw/pcer_i2c_phy.sv
// pin synchroniser and edge, start and stop detector for the serial bus
`timescale 1ns/1ps
module pcer_i2c_phy
    import pcer_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    pcer_i2c_ev_if.phy ev
);
    pcer_phy_s_t s_q;
    pcer_phy_s_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.scl1 = sclIn;
        s_d.scl2 = s_q.scl1;
        s_d.scl3 = s_q.scl2;
        s_d.sda1 = sdaIn;
        s_d.sda2 = s_q.sda1;
        s_d.sda3 = s_q.sda2;
        s_d.rise = s_q.scl2 & ~s_q.scl3;
        s_d.fall = ~s_q.scl2 & s_q.scl3;
        s_d.start = s_q.scl2 & s_q.scl3 & s_q.sda3 & ~s_q.sda2;
        s_d.stop = s_q.scl2 & s_q.scl3 & ~s_q.sda3 & s_q.sda2;
        s_d.sda = s_q.sda2;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '{scl1: 1'b1, scl2: 1'b1, scl3: 1'b1, sda1: 1'b1,
                     sda2: 1'b1, sda3: 1'b1, sda: 1'b1, default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign ev.sclRise = s_q.rise;
    assign ev.sclFall = s_q.fall;
    assign ev.start = s_q.start;
    assign ev.stop = s_q.stop;
    assign ev.sda = s_q.sda;
endmodule

//--- hw/pcer_top.sv
// power control and rail enable registers behind a serial target port
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Functional notes
// R01: trigger bit starts coin-cell measure, self-clears
// R02: enabled power-fail trip shuts all rails off
// R03: disabled power-fail bit leaves power state alone
// R04: control at 0x06, reset zero, bits 7-2 zero
// R05: flag reads one if rail on in suspend
// R06: flags zero after power-up from off
// R07: flag register at 0x07, fixed bit map
// R08: key register always reads back zero
// R09: key register unlocks protected register writes
// R10: rail enable at 0x11, reset zero, key-protected
// R11: enable bits 0-5 drive rails 1-6
// R12: backup rails not cleared once seal broken; writes keep them, but power-fail trip and sequencer (rail 5) clear
// R13: sequencer overrides rails 1-5 enable bits
// R14: status bit 7 shows seal broken
// R15: status state field reports suspend as 3
// R16: host triggers measure before trusting charge level
// R17: reserved bits ignore writes, read zero
// R18: unkeyed protected write is discarded
module pcer_top
    import pcer_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic power_fail_out_n,
    input wire logic [1:0] pwrState,
    input wire logic powerOnFromOff,
    input wire logic seqRailUpd,
    input wire logic [4:0] seqRails,
    input wire logic sealBroken,
    input wire logic [1:0] coin_cell_charge_level,
    input wire logic [3:0] auxRailsOn,
    output logic [5:0] railEnable,
    output logic ccStart,
    output logic pfShutdownReq
);
    pcer_top_s_t s_q;
    pcer_top_s_t s_d;
    logic pfoSync;
    logic pfTrip;
    logic wrCtl;
    logic wrEn;
    logic leaveSusp;
    logic [7:0] byteIn;
    logic [7:0] readVal;

    pcer_i2c_ev_if ev ();

    ////////////////////////////////////////////////////////////////////////
    // pin front ends

    pcer_sync u_pfo (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(power_fail_out_n),
        .dout(pfoSync)
    );

    pcer_i2c_phy u_phy (
        .clk(clk),
        .sys_rst(sys_rst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .ev(ev)
    );

    ////////////////////////////////////////////////////////////////////////
    // register read decode

    function automatic logic [7:0] regRead(
        input logic [7:0] addr,
        input pcer_top_s_t s,
        input logic seal,
        input logic [1:0] state,
        input logic [1:0] charge
    );
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            ADDR_STATUS: begin
                v[STATUS_SEAL_BIT] = seal; // R14
                v[3:2] = state; // R15
                v[1:0] = charge;
            end
            ADDR_CTRL: begin
                v[CTRL_PF_BIT] = s.pfEn; // R04 R17
                v[CTRL_CC_BIT] = s.ccTrig;
            end
            ADDR_FLAGS: v = s.flags;
            ADDR_EN1: v[5:0] = s.enable; // R11 R17
            ADDR_KEY: v = RST_KEY_READ; // R08
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    assign readVal = regRead(s_q.addr, s_q, sealBroken, pwrState,
                             coin_cell_charge_level);
    assign byteIn = {s_q.shreg[6:0], ev.sda};
    assign wrCtl = s_q.wr && (s_q.addr == ADDR_CTRL); // R04
    assign wrEn = s_q.wr && (s_q.addr == ADDR_EN1); // R10
    assign pfTrip = s_q.pfEn && !pfoSync; // R02 R03
    assign leaveSusp = (s_q.prevState == STATE_SUSPEND) &&
                       (pwrState != STATE_SUSPEND);

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;
        s_d.wr = 1'b0;
        s_d.rd = 1'b0;
        s_d.sdaOut = 1'b0;
        s_d.ccTrig = 1'b0; // R01
        s_d.prevState = pwrState;
        if (s_q.wr) begin
            s_d.addr = s_q.addr + 8'h01;
        end
        if (s_q.rd) begin
            s_d.shreg = readVal;
        end
        if (ev.start) begin
            s_d.st = ST_ADDR;
            s_d.cnt = 4'h0;
            s_d.sdaOe = 1'b0;
            s_d.ackPh = 1'b0;
        end else if (ev.stop) begin
            s_d.st = ST_IDLE;
            s_d.sdaOe = 1'b0;
        end else begin
            case (s_q.st)
                ST_ADDR, ST_SUB, ST_DATA: begin
                    if (ev.sclRise) begin
                        s_d.shreg = byteIn;
                        s_d.cnt = s_q.cnt + 4'h1;
                        if (s_q.cnt == 4'h7) begin
                            s_d.cnt = 4'h0;
                            s_d.st = ST_ACK;
                            s_d.ackPh = 1'b0;
                            s_d.after = ST_DATA;
                            if (s_q.st == ST_ADDR) begin
                                if (byteIn[7:1] != DEV_ADDR) begin
                                    s_d.st = ST_IDLE;
                                end else if (byteIn[0]) begin
                                    s_d.after = ST_READ;
                                    s_d.rd = 1'b1;
                                end else begin
                                    s_d.after = ST_SUB;
                                end
                            end else if (s_q.st == ST_SUB) begin
                                s_d.addr = byteIn;
                            end else begin
                                s_d.wr = 1'b1;
                                s_d.wdata = byteIn;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (ev.sclFall) begin
                        if (!s_q.ackPh) begin
                            s_d.ackPh = 1'b1;
                            s_d.sdaOe = 1'b1;
                        end else begin
                            s_d.ackPh = 1'b0;
                            s_d.st = s_q.after;
                            s_d.sdaOe = (s_q.after == ST_READ) &&
                                        !s_q.shreg[7];
                        end
                    end
                end
                ST_READ: begin
                    if (ev.sclRise) begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end else if (ev.sclFall) begin
                        if (s_q.cnt == 4'h8) begin
                            s_d.sdaOe = 1'b0;
                            s_d.st = ST_RACK;
                        end else begin
                            s_d.shreg = {s_q.shreg[6:0], 1'b0};
                            s_d.sdaOe = !s_q.shreg[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (ev.sclRise) begin
                        if (ev.sda) begin
                            s_d.st = ST_IDLE;
                        end else begin
                            s_d.addr = s_q.addr + 8'h01;
                            s_d.st = ST_RLOAD;
                            s_d.ackPh = 1'b0;
                        end
                    end
                end
                ST_RLOAD: begin
                    if (!s_q.ackPh) begin
                        s_d.rd = 1'b1;
                        s_d.ackPh = 1'b1;
                    end
                    if (ev.sclFall) begin
                        s_d.st = ST_READ;
                        s_d.cnt = 4'h0;
                        s_d.ackPh = 1'b0;
                        s_d.sdaOe = !s_q.shreg[7];
                    end
                end
                default: s_d.st = ST_IDLE;
            endcase
        end

        // register writes
        if (wrCtl) begin
            s_d.pfEn = s_q.wdata[CTRL_PF_BIT]; // R17
            s_d.ccTrig = s_q.wdata[CTRL_CC_BIT]; // R01
        end
        if (s_q.wr) begin
            s_d.unlocked = (s_q.addr == ADDR_KEY) &&
                           (s_q.wdata == UNLOCK_KEY); // R09
        end
        if (wrEn && s_q.unlocked) begin // R18
            s_d.enable = s_q.wdata[5:0]; // R11
            if (sealBroken) begin
                s_d.enable[5:4] = s_q.enable[5:4] | s_q.wdata[5:4]; // R12
            end
        end
        if (seqRailUpd) begin
            s_d.enable[4:0] = seqRails; // R13
        end
        s_d.pfShut = pfTrip; // R03
        if (pfTrip) begin
            s_d.enable = RST_EN1[5:0]; // R02
        end

        // resume flags
        if (powerOnFromOff) begin
            s_d.flags = RST_FLAGS; // R06
        end else if (leaveSusp) begin
            s_d.flags = {auxRailsOn, s_q.enable[3:0]}; // R05 R07
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '{st: ST_IDLE, after: ST_IDLE,
                     pfEn: RST_CTRL[CTRL_PF_BIT],
                     ccTrig: RST_CTRL[CTRL_CC_BIT],
                     flags: RST_FLAGS, enable: RST_EN1[5:0],
                     default: '0}; // R04 R10
        end else begin
            s_q <= s_d;
        end
    end

    assign sdaOut = s_q.sdaOut;
    assign sdaOe = s_q.sdaOe;
    assign railEnable = s_q.enable;
    assign ccStart = s_q.ccTrig;
    assign pfShutdownReq = s_q.pfShut;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_cc_trigger;
        @(posedge clk) disable iff (sys_rst)
        wrCtl && s_q.wdata[CTRL_CC_BIT] |=> ccStart ##1 !ccStart;
    endproperty
    a_cc_trigger: assert property (p_cc_trigger) // R01
        else $error("coin-cell trigger did not pulse once");

    property p_pf_shutdown;
        @(posedge clk) disable iff (sys_rst)
        pfTrip |=> pfShutdownReq && (railEnable == 6'h00);
    endproperty
    a_pf_shutdown: assert property (p_pf_shutdown) // R02
        else $error("power-fail trip did not shut rails");

    property p_pf_ignored;
        @(posedge clk) disable iff (sys_rst)
        !s_q.pfEn |=> !pfShutdownReq;
    endproperty
    a_pf_ignored: assert property (p_pf_ignored) // R03
        else $error("power-fail acted while disabled");

    property p_ctrl_reserved;
        @(posedge clk) disable iff (sys_rst)
        s_q.rd && (s_q.addr == ADDR_CTRL) |=> s_q.shreg[7:2] == 6'h00;
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved) // R04
        else $error("control reserved bits read nonzero");

    property p_flags_resume;
        @(posedge clk) disable iff (sys_rst)
        leaveSusp && !powerOnFromOff |=>
            s_q.flags == {$past(auxRailsOn), $past(s_q.enable[3:0])};
    endproperty
    a_flags_resume: assert property (p_flags_resume) // R05
        else $error("resume flags not captured");

    property p_flags_off;
        @(posedge clk) disable iff (sys_rst)
        powerOnFromOff |=> s_q.flags == 8'h00;
    endproperty
    a_flags_off: assert property (p_flags_off) // R06
        else $error("flags not cleared on power-up from off");

    property p_key_reads_zero;
        @(posedge clk) disable iff (sys_rst)
        s_q.rd && (s_q.addr == ADDR_KEY) |=> s_q.shreg == 8'h00;
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero) // R08
        else $error("key register read back nonzero");

    property p_seal_hold;
        @(posedge clk) disable iff (sys_rst)
        wrEn && sealBroken && !pfTrip |=>
            (railEnable[5] || !$past(railEnable[5])) &&
            (railEnable[4] || !$past(railEnable[4]) || $past(seqRailUpd));
    endproperty
    a_seal_hold: assert property (p_seal_hold) // R12
        else $error("backup rail cleared with seal broken");

    property p_seq_override;
        @(posedge clk) disable iff (sys_rst)
        seqRailUpd && !pfTrip |=> railEnable[4:0] == $past(seqRails);
    endproperty
    a_seq_override: assert property (p_seq_override) // R13
        else $error("sequencer update not applied");

    property p_locked_write;
        @(posedge clk) disable iff (sys_rst)
        wrEn && !s_q.unlocked && !seqRailUpd && !pfTrip |=>
            $stable(railEnable) ##1 !s_q.unlocked;
    endproperty
    a_locked_write: assert property (p_locked_write) // R18
        else $error("locked rail enable write took effect");

endmodule

//--- verif/pcer_host_model.sv
// serial bus host model that reaches the register port
`timescale 1ns/1ps
module pcer_host_model
    import pcer_pkg::*;
(
    input wire logic clk,
    output logic scl,
    output logic sdaPull,
    input wire logic sdaWire
);
    int nackCnt = 0;

    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic qp();
        repeat (5) @(posedge clk);
        #1;
    endtask

    // data changes mid-low, sampled at end of high
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            qp();
            sdaPull = ~tx[i];
            qp();
            scl = 1'b1;
            qp();
            qp();
            rx[i] = sdaWire;
            scl = 1'b0;
        end
    endtask

    // start or repeated start
    task automatic start();
        qp();
        sdaPull = 1'b0;
        qp();
        scl = 1'b1;
        qp();
        sdaPull = 1'b1;
        qp();
        scl = 1'b0;
    endtask

    task automatic stop();
        qp();
        sdaPull = 1'b1;
        qp();
        scl = 1'b1;
        qp();
        sdaPull = 1'b0;
        qp();
        qp();
    endtask

    task automatic head(input logic [7:0] sub);
        logic [8:0] r;
        start();
        xfer({DEV_ADDR, 1'b0, 1'b1}, r);
        nackCnt += int'(r[0] !== 1'b0);
        xfer({sub, 1'b1}, r);
        nackCnt += int'(r[0] !== 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] sub, input logic [7:0] d);
        logic [8:0] r;
        head(sub);
        xfer({d, 1'b1}, r);
        nackCnt += int'(r[0] !== 1'b0);
        stop();
    endtask

    // two bytes in one frame land at successive subaddresses
    task automatic wr2(input logic [7:0] sub, input logic [7:0] d0,
                       input logic [7:0] d1);
        logic [8:0] r;
        head(sub);
        xfer({d0, 1'b1}, r);
        nackCnt += int'(r[0] !== 1'b0);
        xfer({d1, 1'b1}, r);
        nackCnt += int'(r[0] !== 1'b0);
        stop();
    endtask

    // unlock before every protected write
    task automatic keyWr(input logic [7:0] sub, input logic [7:0] d);
        wr(ADDR_KEY, UNLOCK_KEY);
        wr(sub, d);
    endtask

    // last byte is not acknowledged to end the read
    task automatic rd(input logic [7:0] sub, output logic [7:0] d);
        logic [8:0] r;
        head(sub);
        start();
        xfer({DEV_ADDR, 1'b1, 1'b1}, r);
        nackCnt += int'(r[0] !== 1'b0);
        xfer(9'h1ff, r);
        d = r[8:1];
        stop();
    endtask

    // first byte acknowledged, so the read moves to the next subaddress
    task automatic rd2(input logic [7:0] sub, output logic [7:0] d0,
                       output logic [7:0] d1);
        logic [8:0] r;
        head(sub);
        start();
        xfer({DEV_ADDR, 1'b1, 1'b1}, r);
        nackCnt += int'(r[0] !== 1'b0);
        xfer(9'h1fe, r);
        d0 = r[8:1];
        xfer(9'h1ff, r);
        d1 = r[8:1];
        stop();
    endtask
endmodule

//--- verif/testbench.sv
// self-checking bench for the power control register block
`timescale 1ns/1ps
module testbench
    import pcer_pkg::*;
;
    logic clk, sys_rst, scl, sdaPull, sdaOut, sdaOe, power_fail_out_n;
    logic powerOnFromOff, seqRailUpd, sealBroken, ccStart, pfShutdownReq;
    logic [1:0] pwrState, coin_cell_charge_level;
    logic [4:0] seqRails;
    logic [3:0] auxRailsOn;
    logic [5:0] railEnable;
    logic [7:0] v, r, r2;
    int errorCnt = 0, numChecks = 0, ccCnt = 0, mEn = 0;
    int seed = 32'heef0;
    logic [7:0] rstSub [5] = '{ADDR_CTRL, ADDR_FLAGS, ADDR_KEY, ADDR_EN1,
                               8'h20};
    wire sdaWire = ~(sdaPull | (sdaOe & ~sdaOut));

    pcer_top dut (.clk(clk), .sys_rst(sys_rst), .sclIn(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .power_fail_out_n(power_fail_out_n),
        .pwrState(pwrState), .powerOnFromOff(powerOnFromOff),
        .seqRailUpd(seqRailUpd), .seqRails(seqRails), .sealBroken(sealBroken),
        .coin_cell_charge_level(coin_cell_charge_level),
        .auxRailsOn(auxRailsOn), .railEnable(railEnable), .ccStart(ccStart),
        .pfShutdownReq(pfShutdownReq));
    pcer_host_model host (.clk(clk), .scl(scl), .sdaPull(sdaPull),
        .sdaWire(sdaWire));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (ccStart === 1'b1) begin
            ccCnt++;
        end
    end

    function automatic int keyedEn(int old, int val, int seal);
        return seal ? ((val & 'h3f) | (old & 'h30)) : (val & 'h3f);
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rdChk(input logic [7:0] sub, input logic [7:0] exp);
        host.rd(sub, r);
        chk(r, exp);
    endtask

    task automatic printVerdict();
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        errorCnt++;
        printVerdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        power_fail_out_n = 1'b1;
        pwrState = 2'h2;
        powerOnFromOff = 1'b0;
        seqRailUpd = 1'b0;
        seqRails = 5'h00;
        sealBroken = 1'b0;
        coin_cell_charge_level = 2'h0;
        auxRailsOn = 4'h0;
        cyc(20);
        sys_rst = 1'b0;
        cyc(5);
        // reset values, unmapped place last
        foreach (rstSub[i]) rdChk(rstSub[i], 8'h00);
        host.wr(ADDR_EN1, 8'h3f);
        rdChk(ADDR_EN1, 8'h00);
        host.wr(ADDR_KEY, UNLOCK_KEY);
        rdChk(ADDR_KEY, 8'h00);
        v = 8'($random(seed));
        host.keyWr(ADDR_EN1, v);
        mEn = keyedEn(mEn, v, 0);
        rdChk(ADDR_EN1, 8'(mEn));
        chk({2'h0, railEnable}, 8'(mEn));
        // trigger pulses once, reserved bits stay zero
        ccCnt = 0;
        host.wr(ADDR_CTRL, 8'hff);
        chk(8'(ccCnt), 8'h01);
        rdChk(ADDR_CTRL, 8'h02);
        host.wr(ADDR_CTRL, 8'h02);
        chk(8'(ccCnt), 8'h01);
        // power-fail trip with shutdown enabled, then disabled
        host.keyWr(ADDR_EN1, 8'h0f);
        power_fail_out_n = 1'b0;
        cyc(6);
        chk({2'h0, railEnable}, 8'h00);
        chk({7'h0, pfShutdownReq}, 8'h01);
        power_fail_out_n = 1'b1;
        cyc(6);
        host.wr(ADDR_CTRL, 8'h00);
        host.keyWr(ADDR_EN1, 8'h2f);
        mEn = 'h2f;
        power_fail_out_n = 1'b0;
        cyc(6);
        chk({2'h0, railEnable}, 8'(mEn));
        chk({7'h0, pfShutdownReq}, 8'h00);
        power_fail_out_n = 1'b1;
        // sequencer load of rails 1 to 5
        v = 8'($random(seed));
        seqRails = v[4:0];
        seqRailUpd = 1'b1;
        cyc(1);
        seqRailUpd = 1'b0;
        cyc(2);
        mEn = (mEn & 'h20) | int'(v[4:0]);
        chk({2'h0, railEnable}, 8'(mEn));
        rdChk(ADDR_EN1, 8'(mEn));
        // suspend exit captures flags, power-up from off clears them
        pwrState = 2'h3;
        auxRailsOn = v[7:4];
        cyc(3);
        pwrState = 2'h2;
        cyc(3);
        rdChk(ADDR_FLAGS, {v[7:4], 4'(mEn)});
        host.rd2(ADDR_CTRL, r, r2);
        chk(r, 8'h00);
        chk(r2, {v[7:4], 4'(mEn)});
        host.wr(ADDR_FLAGS, 8'hff);
        rdChk(ADDR_FLAGS, {v[7:4], 4'(mEn)});
        powerOnFromOff = 1'b1;
        cyc(1);
        powerOnFromOff = 1'b0;
        rdChk(ADDR_FLAGS, 8'h00);
        // status in suspend after a measurement
        pwrState = 2'h3;
        coin_cell_charge_level = v[1:0];
        host.wr(ADDR_CTRL, 8'h01);
        rdChk(ADDR_STATUS, {6'h03, v[1:0]});
        // broken seal keeps backup rails on
        sealBroken = 1'b1;
        host.keyWr(ADDR_EN1, 8'h3f);
        host.keyWr(ADDR_EN1, 8'h00);
        mEn = keyedEn('h3f, 0, 1);
        rdChk(ADDR_EN1, 8'(mEn));
        rdChk(ADDR_STATUS, {6'h23, v[1:0]});
        host.wr2(ADDR_KEY, UNLOCK_KEY, 8'h1f);
        mEn = keyedEn(mEn, 'h1f, 1);
        rdChk(ADDR_EN1, 8'(mEn));
        chk(8'(host.nackCnt), 8'h00);
        printVerdict();
    end
endmodule
